// *** logic/sll_pkg.sv ***
// Package with register map, field layout and carriers of the lane config bank
package sll_pkg;

   // Bus and banking widths
   localparam int SLL_ADDR_W    = 12;
   localparam int SLL_DATA_W    = 8;
   localparam int SLL_LINK_W    = 1;
   localparam int SLL_NUM_LINKS = 2;

   // Register byte offsets
   localparam logic [11:0] SLL_OFF_LINK_PAGE  = 12'h300;
   localparam logic [11:0] SLL_OFF_LANE6_LID  = 12'h43A;
   localparam logic [11:0] SLL_OFF_LANE6_RCHK = 12'h43D;
   localparam logic [11:0] SLL_OFF_LANE6_CCHK = 12'h43E;
   localparam logic [11:0] SLL_OFF_LANE7_LID  = 12'h442;
   localparam logic [11:0] SLL_OFF_LANE7_RCHK = 12'h445;
   localparam logic [11:0] SLL_OFF_LANE7_CCHK = 12'h446;
   localparam logic [11:0] SLL_OFF_LINK_ID    = 12'h450;
   localparam logic [11:0] SLL_OFF_BANK_ID    = 12'h451;
   localparam logic [11:0] SLL_OFF_LANE0_CFG  = 12'h452;
   localparam logic [11:0] SLL_OFF_SCR_L      = 12'h453;
   localparam logic [11:0] SLL_OFF_FRAME      = 12'h454;
   localparam logic [11:0] SLL_OFF_MF         = 12'h455;

   // Field positions
   localparam int SLL_MULTIFRAME_ADJUST_DIRECTION_BIT = 6;
   localparam int SLL_PHASE_ADJUST_REQUEST_BIT  = 5;
   localparam int SLL_DESCR_BIT  = 7;
   localparam int SLL_F5_MSB     = 4;

   // Reset values
   localparam logic       SLL_RST_DESCR = 1'h1;
   localparam logic [4:0] SLL_RST_LANES = 5'h07;
   localparam logic [4:0] SLL_RST_MF    = 5'h1F;
   localparam logic [7:0] SLL_RST_BYTE  = 8'h00;

   // Expected link parameters, one copy per link
   typedef struct packed {
      logic [7:0] linkNumber;
      logic [7:0] bankNumber;
      logic       multiframe_adjust_direction;
      logic       phaseAdj;
      logic [4:0] laneNum;
      logic       descrEn;
      logic [4:0] laneCount;
      logic [7:0] frameSize;
      logic [4:0] mfLength;
   } sll_cfg_t;

   localparam sll_cfg_t SLL_CFG_RST = '{
      linkNumber: SLL_RST_BYTE, bankNumber: SLL_RST_BYTE,
      multiframe_adjust_direction: 1'h0, phaseAdj: 1'h0, laneNum: 5'h00,
      descrEn: SLL_RST_DESCR, laneCount: SLL_RST_LANES,
      frameSize: SLL_RST_BYTE, mfLength: SLL_RST_MF};

   // Alignment-sequence configuration as received on one lane
   typedef struct packed {
      logic                  valid;
      logic [SLL_LINK_W-1:0] link;
      logic [7:0]            link_number;
      logic [3:0]            bank_number;
      logic [3:0]            adjCnt;
      logic [4:0]            lid;
      logic                  phase_adjust_request;
      logic                  multiframe_adjust_direction;
      logic [4:0]            lanes;
      logic                  descramble_enable;
      logic [7:0]            octets;
      logic [4:0]            frames;
      logic [7:0]            convs;
      logic [1:0]            ctrlBits;
      logic [4:0]            resol;
      logic [2:0]            subclass;
      logic [4:0]            sampBits;
      logic [2:0]            version;
      logic [4:0]            samples;
      logic                  hd;
      logic [4:0]            ctrlWords;
      logic [7:0]            chk;
   } sll_ilas_t;

   // Captured status of one lane
   typedef struct packed {
      logic [4:0] laneNum;
      logic [7:0] rxChk;
      logic [7:0] calcChk;
   } sll_lane_stat_t;

   // Modulo-256 sum of the received configuration fields
   function automatic logic [7:0] sll_calc_checksum(input sll_ilas_t c);
      logic [7:0] s;
      s = c.link_number + 8'(c.bank_number) + 8'(c.adjCnt) + 8'(c.lid) + 8'(c.phase_adjust_request);
      s = s + 8'(c.multiframe_adjust_direction) + 8'(c.lanes) + 8'(c.descramble_enable) + c.octets;
      s = s + 8'(c.frames) + c.convs + 8'(c.ctrlBits) + 8'(c.resol);
      s = s + 8'(c.subclass) + 8'(c.sampBits) + 8'(c.version);
      s = s + 8'(c.samples) + 8'(c.hd) + 8'(c.ctrlWords);
      return s;
   endfunction : sll_calc_checksum

endpackage : sll_pkg

// *** logic/sll_lane_config_regs.sv ***
// Per-link register bank for lane six/seven captures and link parameters
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RL1: All registers banked; page register selects link
// RL2: Capture lanes 6/7 received lane number
// RL3: Store lanes 6/7 received checksum, read-only
// RL4: Expose lanes 6/7 computed checksum read-only
// RL5: Link number byte, read-write, reset zero
// RL6: Bank number byte, read-write, reset zero
// RL7: Software changes bank/lane only in deframer reset
// RL8: Adjust direction bit six, link zero only
// RL9: Phase adjust request bit five, link zero
// RL10: Lane number in bits four to zero
// RL11: Descramble enable bit seven, resets to one
// RL12: Lane count minus one, resets to seven
// RL13: Octets per frame minus one, resets zero
// RL14: Frames per multiframe minus one, reset 0x1F
// RL15: Computed checksum is modulo-256 field sum
// RL16: Reserved bits read zero, writes ignored
module sll_lane_config_regs
   import sll_pkg::*;
#(
   parameter int NUM_LINKS = SLL_NUM_LINKS
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic [SLL_ADDR_W-1:0]      addr,
   input  wire logic [SLL_DATA_W-1:0]      wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output var  logic [SLL_DATA_W-1:0]      rdata,
   input  wire sll_ilas_t                  lane6Ilas,
   input  wire sll_ilas_t                  lane7Ilas,
   output var  sll_cfg_t [NUM_LINKS-1:0]   linkCfg
);

   logic                            rstMeta;
   logic                            rstN;
   logic [SLL_LINK_W-1:0]           linkPage;
   logic [SLL_LINK_W-1:0]           next_linkPage;
   sll_cfg_t [NUM_LINKS-1:0]        next_linkCfg;
   sll_lane_stat_t [NUM_LINKS-1:0]  lane6Stat;
   sll_lane_stat_t [NUM_LINKS-1:0]  lane7Stat;
   sll_lane_stat_t [NUM_LINKS-1:0]  next_lane6Stat;
   sll_lane_stat_t [NUM_LINKS-1:0]  next_lane7Stat;
   logic [SLL_DATA_W-1:0]           next_rdata;
   logic                            pageOk;
   logic                            upperAdj;

   // Build the stored record of one lane's alignment sequence
   function automatic sll_lane_stat_t lane_capture(input sll_ilas_t c);
      sll_lane_stat_t r;
      r.laneNum = c.lid;
      r.rxChk   = c.chk;
      r.calcChk = sll_calc_checksum(c);   // [RL15]
      return r;
   endfunction : lane_capture

   // Reset release through two flops; asynchronous assert only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta <= 1'b0;
         rstN    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN    <= rstMeta;
      end
   end

   // Pages beyond the built link count reach nothing
   assign pageOk = (32'(linkPage) < NUM_LINKS);

   // Register writes; reserved bits are simply never stored
   always_comb begin
      next_linkPage = linkPage;
      next_linkCfg  = linkCfg;
      if (wr) begin
         case (addr)
            SLL_OFF_LINK_PAGE: begin
               next_linkPage = wdata[SLL_LINK_W-1:0];        // [RL1]
            end
            SLL_OFF_LINK_ID: begin
               if (pageOk) begin
                  next_linkCfg[linkPage].linkNumber = wdata;   // [RL5]
               end
            end
            SLL_OFF_BANK_ID: begin
               if (pageOk) begin
                  next_linkCfg[linkPage].bankNumber = wdata;   // [RL6]
               end
            end
            SLL_OFF_LANE0_CFG: begin
               if (pageOk) begin
                  next_linkCfg[linkPage].laneNum =
                     wdata[SLL_F5_MSB:0];                      // [RL10]
               end
               // Phase controls exist on link zero only
               if (linkPage == '0) begin
                  next_linkCfg[0].multiframe_adjust_direction   = wdata[SLL_MULTIFRAME_ADJUST_DIRECTION_BIT]; // [RL8]
                  next_linkCfg[0].phaseAdj = wdata[SLL_PHASE_ADJUST_REQUEST_BIT];  // [RL9]
               end
            end
            SLL_OFF_SCR_L: begin
               if (pageOk) begin
                  next_linkCfg[linkPage].descrEn =
                     wdata[SLL_DESCR_BIT];                     // [RL11]
                  next_linkCfg[linkPage].laneCount =
                     wdata[SLL_F5_MSB:0];                      // [RL12]
               end
            end
            SLL_OFF_FRAME: begin
               if (pageOk) begin
                  next_linkCfg[linkPage].frameSize = wdata;    // [RL13]
               end
            end
            SLL_OFF_MF: begin
               if (pageOk) begin
                  next_linkCfg[linkPage].mfLength =
                     wdata[SLL_F5_MSB:0];                      // [RL14]
               end
            end
            default: begin
               next_linkPage = linkPage;
            end
         endcase
      end
   end

   // Configuration and page registers
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         linkPage <= '0;
         linkCfg  <= {NUM_LINKS{SLL_CFG_RST}};
      end else begin
         linkPage <= next_linkPage;
         linkCfg  <= next_linkCfg;
      end
   end

   // Alignment-sequence capture, filed under the link it arrived on
   always_comb begin
      next_lane6Stat = lane6Stat;
      next_lane7Stat = lane7Stat;
      if (lane6Ilas.valid && (32'(lane6Ilas.link) < NUM_LINKS)) begin
         next_lane6Stat[lane6Ilas.link] = lane_capture(lane6Ilas); // [RL2]
      end
      if (lane7Ilas.valid && (32'(lane7Ilas.link) < NUM_LINKS)) begin
         next_lane7Stat[lane7Ilas.link] = lane_capture(lane7Ilas); // [RL3]
      end
   end

   // Capture registers, cleared only by reset
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         lane6Stat <= '0;
         lane7Stat <= '0;
      end else begin
         lane6Stat <= next_lane6Stat;
         lane7Stat <= next_lane7Stat;
      end
   end

   // Read mux; unmapped and reserved bits answer zero
   always_comb begin
      next_rdata = '0;
      if (rd) begin
         if (addr == SLL_OFF_LINK_PAGE) begin
            next_rdata = 8'(linkPage);                          // [RL1]
         end else if (pageOk) begin
            case (addr)
               SLL_OFF_LANE6_LID:
                  next_rdata = 8'(lane6Stat[linkPage].laneNum); // [RL2]
               SLL_OFF_LANE6_RCHK:
                  next_rdata = lane6Stat[linkPage].rxChk;       // [RL3]
               SLL_OFF_LANE6_CCHK:
                  next_rdata = lane6Stat[linkPage].calcChk;     // [RL4]
               SLL_OFF_LANE7_LID:
                  next_rdata = 8'(lane7Stat[linkPage].laneNum); // [RL2]
               SLL_OFF_LANE7_RCHK:
                  next_rdata = lane7Stat[linkPage].rxChk;
               SLL_OFF_LANE7_CCHK:
                  next_rdata = lane7Stat[linkPage].calcChk;
               SLL_OFF_LINK_ID:
                  next_rdata = linkCfg[linkPage].linkNumber;
               SLL_OFF_BANK_ID:
                  next_rdata = linkCfg[linkPage].bankNumber;
               SLL_OFF_LANE0_CFG: begin
                  next_rdata = 8'(linkCfg[linkPage].laneNum);
                  next_rdata[SLL_MULTIFRAME_ADJUST_DIRECTION_BIT] = linkCfg[linkPage].multiframe_adjust_direction;
                  next_rdata[SLL_PHASE_ADJUST_REQUEST_BIT]  = linkCfg[linkPage].phaseAdj;
               end
               SLL_OFF_SCR_L: begin
                  next_rdata = 8'(linkCfg[linkPage].laneCount);
                  next_rdata[SLL_DESCR_BIT] = linkCfg[linkPage].descrEn;
               end
               SLL_OFF_FRAME:
                  next_rdata = linkCfg[linkPage].frameSize;
               SLL_OFF_MF:
                  next_rdata = 8'(linkCfg[linkPage].mfLength);
               default:
                  next_rdata = '0;                              // [RL16]
            endcase
         end
      end
   end

   // Read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Checking helper: any phase control set outside link zero
   always_comb begin
      upperAdj = 1'b0;
      for (int i = 1; i < NUM_LINKS; i++) begin
         upperAdj = upperAdj | linkCfg[i].multiframe_adjust_direction | linkCfg[i].phaseAdj;
      end
   end

   // Assertions
   a_page_write_lands: assert property (@(posedge clk) disable iff (!rstN)
      (wr && addr == SLL_OFF_LINK_ID && pageOk)
      |=> (linkCfg[$past(linkPage)].linkNumber == $past(wdata)))
      else $error("link number write missed its page"); // [RL1]
   a_link_number_rw: assert property (@(posedge clk) disable iff (!rstN)
      (wr && addr == SLL_OFF_LINK_ID && pageOk)
      ##1 (rd && addr == SLL_OFF_LINK_ID && $stable(linkPage))
      |=> (rdata == $past(wdata, 2)))
      else $error("link number read back wrong"); // [RL5]
   a_bank_number_rw: assert property (@(posedge clk) disable iff (!rstN)
      (wr && addr == SLL_OFF_BANK_ID && pageOk)
      |=> (linkCfg[$past(linkPage)].bankNumber == $past(wdata)))
      else $error("bank number not stored"); // [RL6]
   a_lane6_capture: assert property (@(posedge clk) disable iff (!rstN)
      (lane6Ilas.valid && lane6Ilas.link == '0)
      |=> (lane6Stat[0].laneNum == $past(lane6Ilas.lid)))
      else $error("lane six lane number not captured"); // [RL2]
   a_lane7_rx_chk: assert property (@(posedge clk) disable iff (!rstN)
      (lane7Ilas.valid && lane7Ilas.link == '0)
      |=> (lane7Stat[0].rxChk == $past(lane7Ilas.chk)))
      else $error("lane seven checksum not stored"); // [RL3]
   a_calc_checksum: assert property (@(posedge clk) disable iff (!rstN)
      (lane6Ilas.valid && lane6Ilas.link == '0)
      |=> (lane6Stat[0].calcChk == sll_calc_checksum($past(lane6Ilas))))
      else $error("computed checksum wrong"); // [RL4] [RL15]
   a_upper_no_adjust: assert property (@(posedge clk) disable iff (!rstN)
      !upperAdj)
      else $error("phase control set outside link zero"); // [RL8] [RL9]
   a_lane0_cfg_write: assert property (@(posedge clk) disable iff (!rstN)
      (wr && addr == SLL_OFF_LANE0_CFG && linkPage == '0)
      |=> (linkCfg[0].phaseAdj == $past(wdata[SLL_PHASE_ADJUST_REQUEST_BIT])
           && linkCfg[0].multiframe_adjust_direction == $past(wdata[SLL_MULTIFRAME_ADJUST_DIRECTION_BIT])
           && linkCfg[0].laneNum == $past(wdata[SLL_F5_MSB:0])))
      else $error("lane zero config not stored"); // [RL10]
   a_reset_values: assert property (@(posedge clk)
      $rose(rstN) |-> (linkCfg[0].descrEn == SLL_RST_DESCR
         && linkCfg[0].laneCount == SLL_RST_LANES
         && linkCfg[0].mfLength == SLL_RST_MF
         && linkCfg[0].frameSize == SLL_RST_BYTE))
      else $error("link parameters wrong after reset"); // [RL11] [RL12]
   a_frame_mf_write: assert property (@(posedge clk) disable iff (!rstN)
      (wr && addr == SLL_OFF_MF && linkPage == '0)
      |=> (linkCfg[0].mfLength == $past(wdata[SLL_F5_MSB:0]))
      ##1 ($past(wr) || linkCfg[0].mfLength
           == $past(wdata[SLL_F5_MSB:0], 2)))
      else $error("multiframe length not held"); // [RL14]
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rstN)
      (rd && addr == SLL_OFF_SCR_L) |=> (rdata[6:5] == 2'h0))
      else $error("reserved bits read nonzero"); // [RL16]
   a_read_one_cycle: assert property (@(posedge clk) disable iff (!rstN)
      !rd |=> (rdata == '0))
      else $error("read data stood without a strobe"); // [RL16]

   c_page_switch: cover property (@(posedge clk) disable iff (!rstN)
      (wr && addr == SLL_OFF_LINK_PAGE && wdata[0]) ##1
      (wr && addr == SLL_OFF_LINK_ID));
   c_both_captures: cover property (@(posedge clk) disable iff (!rstN)
      lane6Ilas.valid && lane7Ilas.valid);
   c_checksum_mismatch: cover property (@(posedge clk) disable iff (!rstN)
      lane6Stat[0].rxChk != lane6Stat[0].calcChk);
   c_back_to_back: cover property (@(posedge clk) disable iff (!rstN)
      wr ##1 rd ##1 rd);

endmodule : sll_lane_config_regs

`default_nettype wire

// *** testbench/sll_ilas_tx_model.sv ***
// Behavioural link transmitter sending alignment configuration per lane
`timescale 1ns/100ps
`default_nettype none
module sll_ilas_tx_model
   import sll_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       go,
   input  wire logic       goLane,
   input  wire logic       goLink,
   input  wire logic       goBad,
   input  wire logic [7:0] goSeed,
   output var  sll_ilas_t  lane6Ilas,
   output var  sll_ilas_t  lane7Ilas
);
   sll_ilas_t frame;

   // Fixed link setup; the seed varies the identifiers
   always_comb begin
      frame          = '0;
      frame.valid    = 1'b1;
      frame.link     = goLink;
      frame.link_number      = goSeed;
      frame.bank_number      = goSeed[3:0];
      frame.adjCnt   = 4'h3;
      frame.lid      = goSeed[4:0];
      frame.phase_adjust_request    = 1'b1;
      frame.lanes    = 5'h07;
      frame.descramble_enable      = 1'b1;
      frame.octets   = 8'h01;
      frame.frames   = 5'h1F;
      frame.convs    = 8'h01;
      frame.resol    = 5'h0F;
      frame.subclass = 3'h1;
      frame.sampBits = 5'h0F;
      frame.version  = 3'h1;
      // Own field sum; a bad frame carries it off by one
      frame.chk = 8'(frame.link_number + frame.bank_number + frame.adjCnt + frame.lid
                  + frame.phase_adjust_request + frame.multiframe_adjust_direction + frame.lanes + frame.descramble_enable
                  + frame.octets + frame.frames + frame.convs
                  + frame.ctrlBits + frame.resol + frame.subclass
                  + frame.sampBits + frame.version + frame.samples
                  + frame.hd + frame.ctrlWords + goBad);
   end

   // Idle lanes show inverted garbage so stale data cannot pass
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lane6Ilas <= '0;
         lane7Ilas <= '0;
      end else begin
         lane6Ilas <= (go && !goLane) ? frame :
                      {1'b0, ~lane6Ilas[$bits(sll_ilas_t)-2:0]};
         lane7Ilas <= (go && goLane) ? frame :
                      {1'b0, ~lane7Ilas[$bits(sll_ilas_t)-2:0]};
      end
   end
endmodule : sll_ilas_tx_model
`default_nettype wire

// *** testbench/sll_lane_config_regs_tb_top.sv ***
// Self-checking bench for the lane config register bank
`timescale 1ns/100ps
`default_nettype none
module sll_lane_config_regs_tb_top;
   import sll_pkg::*;
   logic                  clk;
   logic                  rst_b;
   logic                  wr;
   logic                  rd;
   logic                  go;
   logic                  goLane;
   logic                  goLink;
   logic                  goBad;
   logic [7:0]            goSeed;
   logic [11:0]           addr;
   logic [7:0]            wdata;
   logic [7:0]            rdata;
   sll_ilas_t             lane6Ilas;
   sll_ilas_t             lane7Ilas;
   sll_cfg_t [1:0]        linkCfg;
   int                    badCount;
   int                    compares;
   logic [11:0]           rstAddr [13];
   logic [7:0]            rstVal [13];

   sll_lane_config_regs #(.NUM_LINKS(2)) dut (
      .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .lane6Ilas(lane6Ilas),
      .lane7Ilas(lane7Ilas), .linkCfg(linkCfg));

   sll_ilas_tx_model tx (
      .clk(clk), .rst_b(rst_b), .go(go), .goLane(goLane),
      .goLink(goLink), .goBad(goBad), .goSeed(goSeed),
      .lane6Ilas(lane6Ilas), .lane7Ilas(lane7Ilas));

   // Free running clock, 100 ns period
   always #50 clk = ~clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // Write then read back with no gap between the strobes
   task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge clk);
      rd    <= 1'b0;
      #1 check(rdata, d);
   endtask : wr_rd

   // Data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1 check(rdata, exp);
   endtask : rd_chk

   task automatic send(input logic l, input logic k, input logic [7:0] s,
                       input logic b);
      @(posedge clk);
      go     <= 1'b1;
      goLane <= l;
      goLink <= k;
      goSeed <= s;
      goBad  <= b;
      @(posedge clk);
      go     <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : send

   // Field sum worked out from the transmitter's fixed setup
   function automatic logic [7:0] exp_sum(input logic [7:0] s);
      return 8'(8'h4D + s + s[3:0] + s[4:0]);
   endfunction : exp_sum

   task automatic finish_test();
      if (badCount == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge clk);
      badCount++;
      finish_test();
   end

   initial begin
      clk = 1'b0; rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 12'h000;
      wdata = 8'h00; go = 1'b0; goLane = 1'b0; goLink = 1'b0;
      goBad = 1'b0; goSeed = 8'h00; badCount = 0; compares = 0;
      rstAddr = '{12'h300, 12'h43A, 12'h43D, 12'h43E, 12'h442, 12'h445,
                  12'h446, 12'h450, 12'h451, 12'h452, 12'h453, 12'h454,
                  12'h455};
      rstVal  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                  8'h00, 8'h00, 8'h00, 8'h87, 8'h00, 8'h1F};
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values of every register
      for (int i = 0; i < 13; i++)
         rd_chk(rstAddr[i], rstVal[i]);
      check(8'(linkCfg[1].laneCount), 8'h07);
      // Identifiers written as if the deframer is held in soft reset
      wr_reg(12'h450, 8'hA5);
      wr_reg(12'h451, 8'h3C);
      wr_reg(12'h452, 8'hFF);
      wr_reg(12'h453, 8'h7F);
      wr_reg(12'h454, 8'h7E);
      wr_reg(12'h455, 8'hE3);
      rd_chk(12'h450, 8'hA5);
      rd_chk(12'h451, 8'h3C);
      rd_chk(12'h452, 8'h7F);
      rd_chk(12'h453, 8'h1F);
      rd_chk(12'h454, 8'h7E);
      rd_chk(12'h455, 8'h03);
      @(posedge clk);
      #1 check(rdata, 8'h00);
      check(8'(linkCfg[0].multiframe_adjust_direction), 8'h01);
      check(8'(linkCfg[0].descrEn), 8'h00);
      // Second link keeps its own copy; lane-zero extras on link 0 only
      wr_reg(12'h300, 8'hFF);
      rd_chk(12'h300, 8'h01);
      rd_chk(12'h450, 8'h00);
      wr_reg(12'h452, 8'hFF);
      rd_chk(12'h452, 8'h1F);
      check(8'(linkCfg[1].phaseAdj), 8'h00);
      wr_reg(12'h300, 8'h00);
      rd_chk(12'h450, 8'hA5);
      wr_rd(12'h450, 8'h96);
      // Read-only and unmapped places ignore writes
      wr_reg(12'h43D, 8'h5A);
      rd_chk(12'h43D, 8'h00);
      wr_reg(12'h457, 8'h5A);
      rd_chk(12'h457, 8'h00);
      // Captures: good frame on lane 6 link 0, bad one on lane 7 link 1
      send(1'b0, 1'b0, 8'h5A, 1'b0);
      send(1'b1, 1'b1, 8'hC3, 1'b1);
      rd_chk(12'h43A, 8'h1A);
      rd_chk(12'h43D, exp_sum(8'h5A));
      rd_chk(12'h43E, exp_sum(8'h5A));
      rd_chk(12'h442, 8'h00);
      wr_reg(12'h300, 8'h01);
      rd_chk(12'h442, 8'h03);
      rd_chk(12'h445, 8'(exp_sum(8'hC3) + 8'h01));
      rd_chk(12'h446, exp_sum(8'hC3));
      rd_chk(12'h43A, 8'h00);
      finish_test();
   end
endmodule : sll_lane_config_regs_tb_top
`default_nettype wire
